// *** common/abx_params.svh ***
// constants for the arithmetic/branch execution slice
// assumes 14-bit instruction words and a 13-bit program counter
`ifndef ABX_PARAMS_SVH
`define ABX_PARAMS_SVH
`define ABX_OPC_COMPLEMENT   6'h09
`define ABX_OPC_DECREMENT    6'h03
`define ABX_OPC_DEC_SKIP     6'h0B
`define ABX_OPC_INC_SKIP     6'h0F
`define ABX_OPC_OR_LITERAL   6'h38
`define ABX_OPC_BRANCH       3'h5
`define ABX_DEST_BIT         7
`define ABX_PC_RESET         13'h0000
`define ABX_ACC_RESET        8'h00
`endif

// *** common/abx_pkg.sv ***
// types for the arithmetic/branch execution slice
// assumes abx_params.svh defines the encodings
package abx_pkg;
  typedef enum logic [2:0] {
    ABX_ST_EXEC  = 3'b001,
    ABX_ST_FLUSH = 3'b010,
    ABX_ST_IDLE  = 3'b100
  } abx_state_t;
  typedef logic [12:0] abx_pc_t;
  typedef logic [13:0] abx_instr_t;
endpackage

// *** core/abx_exec.sv ***
// execution core for complement, decrement, skip, branch and or-literal
// assumes one instruction word per ref_clk cycle from program memory,
// and a combinational file register read port addressed by file_addr
`timescale 1ns/100ps
`default_nettype none
`include "abx_params.svh"
module abx_exec (
  // clock and reset
  input  wire logic           ref_clk,
  input  wire logic           reset,
  // instruction stream
  input  wire abx_pkg::abx_instr_t instr,
  input  wire logic           instr_valid,
  input  wire logic [7:0]     pc_high_latch,
  // file register port
  output logic [6:0]          file_addr,
  input  wire logic [7:0]     file_rdata,
  output logic                file_we,
  output logic [7:0]          file_wdata,
  // core state
  output abx_pkg::abx_pc_t    pc,
  output logic [7:0]          accum,
  output logic                zero_flag,
  output logic                discard
);
  import abx_pkg::*;

  abx_state_t state_r;
  abx_state_t state_nxt;
  abx_pc_t    pc_r;
  logic [7:0] acc_r;
  logic       z_r;
  logic [7:0] fwdata_r;
  logic       fwe_r;
  logic [7:0] result;
  logic       dest_file;
  logic       writes_z;
  logic       is_skip;
  logic       is_branch;
  logic       is_reg_op;
  logic       executing;

  function automatic logic op_is(input abx_instr_t w, input logic [5:0] opc);
    op_is = (w[13:8] == opc);
  endfunction

  assign executing = instr_valid && (state_r == ABX_ST_EXEC);
  assign dest_file = instr[`ABX_DEST_BIT];
  assign is_branch = (instr[13:11] == `ABX_OPC_BRANCH);
  assign is_skip   = op_is(instr, `ABX_OPC_DEC_SKIP) || op_is(instr, `ABX_OPC_INC_SKIP);
  assign is_reg_op = op_is(instr, `ABX_OPC_COMPLEMENT) || op_is(instr, `ABX_OPC_DECREMENT)
                     || is_skip;
  assign writes_z  = op_is(instr, `ABX_OPC_COMPLEMENT) || op_is(instr, `ABX_OPC_DECREMENT)
                     || op_is(instr, `ABX_OPC_OR_LITERAL);
  assign file_addr = instr[6:0];

  always_comb begin
    result = 8'h00;
    case (instr[13:8])
      `ABX_OPC_COMPLEMENT: result = ~file_rdata;
      `ABX_OPC_DECREMENT:  result = file_rdata - 8'h01;
      `ABX_OPC_DEC_SKIP:   result = file_rdata - 8'h01;
      `ABX_OPC_INC_SKIP:   result = file_rdata + 8'h01;
      `ABX_OPC_OR_LITERAL: result = acc_r | instr[7:0];
      default:             result = 8'h00;
    endcase
  end

  // a flush cycle drops the word fetched behind a branch or a taken skip
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ABX_ST_IDLE:  state_nxt = ABX_ST_EXEC;
      ABX_ST_EXEC: begin
        if (executing && is_branch)
          state_nxt = ABX_ST_FLUSH;
        else if (executing && op_is(instr, `ABX_OPC_DEC_SKIP) && result == 8'h00)
          state_nxt = ABX_ST_FLUSH;
        else if (executing && op_is(instr, `ABX_OPC_INC_SKIP) && result == 8'h00)
          state_nxt = ABX_ST_FLUSH;
      end
      ABX_ST_FLUSH: if (instr_valid) state_nxt = ABX_ST_EXEC;
      default:      state_nxt = ABX_ST_EXEC;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) state_r <= ABX_ST_IDLE;
    else       state_r <= state_nxt;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pc_r <= `ABX_PC_RESET;
    end else if (executing && is_branch) begin
      pc_r <= {pc_high_latch[4:3], instr[10:0]};
    end else if (instr_valid) begin
      pc_r <= pc_r + 13'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      acc_r <= `ABX_ACC_RESET;
    end else if (executing && op_is(instr, `ABX_OPC_OR_LITERAL)) begin
      acc_r <= result;
    end else if (executing && is_reg_op && !dest_file) begin
      acc_r <= result;
    end
  end

  // skip forms leave the zero flag alone
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)                     z_r <= 1'b0;
    else if (executing && writes_z) z_r <= (result == 8'h00);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fwe_r    <= 1'b0;
      fwdata_r <= 8'h00;
    end else begin
      // the file space keeps the address of the previous cycle itself
      fwe_r    <= executing && is_reg_op && dest_file;
      fwdata_r <= result;
    end
  end

  assign pc         = pc_r;
  assign accum      = acc_r;
  assign zero_flag  = z_r;
  assign file_we    = fwe_r;
  assign file_wdata = fwdata_r;
  assign discard    = (state_r == ABX_ST_FLUSH);

  a_comp_to_acc: assert property (@(posedge ref_clk) disable iff (reset)
    executing && op_is(instr, `ABX_OPC_COMPLEMENT) && !dest_file
    |=> acc_r == ~$past(file_rdata))
    else $error("complement result wrong");
  a_dec_to_file: assert property (@(posedge ref_clk) disable iff (reset)
    executing && op_is(instr, `ABX_OPC_DECREMENT) && dest_file
    |=> fwe_r && fwdata_r == $past(file_rdata) - 8'h01)
    else $error("decrement file write wrong");
  a_skip_keeps_z: assert property (@(posedge ref_clk) disable iff (reset)
    executing && is_skip |=> z_r == $past(z_r))
    else $error("skip op changed zero flag");
  a_inc_skip_flush: assert property (@(posedge ref_clk) disable iff (reset)
    executing && op_is(instr, `ABX_OPC_INC_SKIP) && file_rdata == 8'hFF |=> discard)
    else $error("increment skip did not flush");
  a_branch_target: assert property (@(posedge ref_clk) disable iff (reset)
    executing && is_branch |=> pc_r == {$past(pc_high_latch[4:3]), $past(instr[10:0])})
    else $error("branch target wrong");
  a_branch_flush: assert property (@(posedge ref_clk) disable iff (reset)
    executing && is_branch |=> discard ##1 !discard || !$past(instr_valid))
    else $error("branch not two cycles");
  a_or_literal: assert property (@(posedge ref_clk) disable iff (reset)
    executing && op_is(instr, `ABX_OPC_OR_LITERAL)
    |=> acc_r == ($past(acc_r) | $past(instr[7:0])) && z_r == (acc_r == 8'h00))
    else $error("or literal wrong");
  a_no_skip_nonzero: assert property (@(posedge ref_clk) disable iff (reset)
    executing && op_is(instr, `ABX_OPC_DEC_SKIP) && file_rdata != 8'h01 |=> !discard)
    else $error("skip taken on nonzero");
  a_comp_zero: assert property (@(posedge ref_clk) disable iff (reset)
    executing && op_is(instr, `ABX_OPC_COMPLEMENT)
    |=> z_r == ($past(file_rdata) == 8'hFF))
    else $error("complement zero flag wrong");
  a_dec_zero: assert property (@(posedge ref_clk) disable iff (reset)
    executing && op_is(instr, `ABX_OPC_DECREMENT)
    |=> z_r == ($past(file_rdata) == 8'h01))
    else $error("decrement zero flag wrong");
  a_dec_skip_flush: assert property (@(posedge ref_clk) disable iff (reset)
    executing && op_is(instr, `ABX_OPC_DEC_SKIP) && file_rdata == 8'h01
    |=> discard)
    else $error("decrement skip did not flush");
  a_dec_skip_route: assert property (@(posedge ref_clk) disable iff (reset)
    executing && op_is(instr, `ABX_OPC_DEC_SKIP) && dest_file
    |=> fwe_r && fwdata_r == $past(file_rdata) - 8'h01)
    else $error("decrement skip file write wrong");
  a_inc_skip_route: assert property (@(posedge ref_clk) disable iff (reset)
    executing && op_is(instr, `ABX_OPC_INC_SKIP) && !dest_file
    |=> !fwe_r && acc_r == $past(file_rdata) + 8'h01)
    else $error("increment skip accumulator wrong");
  a_flush_quiet: assert property (@(posedge ref_clk) disable iff (reset)
    discard |=> $stable(acc_r) && $stable(z_r) && !fwe_r)
    else $error("flushed word changed state");

  c_branch:   cover property (@(posedge ref_clk) disable iff (reset) executing && is_branch);
  c_skip:     cover property (@(posedge ref_clk) disable iff (reset)
    executing && is_skip ##1 discard);
  c_or_zero:  cover property (@(posedge ref_clk) disable iff (reset)
    executing && op_is(instr, `ABX_OPC_OR_LITERAL) ##1 z_r);
  c_inc_skip: cover property (@(posedge ref_clk) disable iff (reset)
    executing && op_is(instr, `ABX_OPC_INC_SKIP) ##1 discard);
  c_flush_wait: cover property (@(posedge ref_clk) disable iff (reset)
    discard && !instr_valid);
endmodule
`default_nettype wire

// *** sim/abx_fmem.sv ***
// file register space model on the far side of the execution core
// assumes file_we/file_wdata refer to the address shown one cycle before
`timescale 1ns/100ps
`default_nettype none
module abx_fmem (
  // clock
  input  wire logic       ref_clk,
  // core port
  input  wire logic [6:0] file_addr,
  output logic [7:0]      file_rdata,
  input  wire logic       file_we,
  input  wire logic [7:0] file_wdata
);
  logic [7:0] mem [0:127];
  logic [6:0] wr_addr_r;
  // forward a pending write so back-to-back access sees the new value
  assign file_rdata = (file_we && wr_addr_r == file_addr) ? file_wdata : mem[file_addr];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'h00;
  always @(posedge ref_clk) begin
    wr_addr_r <= file_addr;
    if (file_we) mem[wr_addr_r] <= file_wdata;
  end
endmodule
`default_nettype wire

// *** sim/arith_branch_instr_exec_test.sv ***
// random instruction stream against a reference model of the core
// assumes abx_fmem answers file reads with write forwarding
`timescale 1ns/100ps
`default_nettype none
`include "abx_params.svh"
module arith_branch_instr_exec_test;
  import abx_pkg::*;
  logic ref_clk = 0, reset = 1, instr_valid = 0, file_we, zero_flag, discard;
  abx_instr_t instr = '0;
  logic [7:0] pc_high_latch = '0, file_rdata, file_wdata, accum, e_acc = 0, e_wd, v, r;
  logic [6:0] file_addr;
  abx_pc_t pc, e_pc = 0;
  logic e_z = 0, e_we, e_skip = 0;
  logic [7:0] m [0:127];
  logic [5:0] ops [7] = '{`ABX_OPC_COMPLEMENT, `ABX_OPC_DECREMENT, `ABX_OPC_DEC_SKIP,
    `ABX_OPC_INC_SKIP, `ABX_OPC_OR_LITERAL, {`ABX_OPC_BRANCH, 3'h0}, 6'h00};
  int err_count = 0, n_checks = 0, k;
  logic [13:0] w;
  always #10 ref_clk = ~ref_clk;
  abx_exec dut (.ref_clk(ref_clk), .reset(reset), .instr(instr), .instr_valid(instr_valid),
    .pc_high_latch(pc_high_latch), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_we(file_we), .file_wdata(file_wdata), .pc(pc), .accum(accum),
    .zero_flag(zero_flag), .discard(discard));
  abx_fmem fm (.ref_clk(ref_clk), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_we(file_we), .file_wdata(file_wdata));
  task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_addr(input logic [12:0] got, input logic [12:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // reset held 12 cycles and released at a falling edge, then the idle edge
  task automatic do_reset;
    reset = 1;
    repeat (12) @(negedge ref_clk);
    reset = 0;
    e_acc = `ABX_ACC_RESET;
    e_pc = `ABX_PC_RESET;
    e_z = 1'b0;
    e_skip = 1'b0;
    cmp_addr(pc, e_pc);
    cmp_data(accum, e_acc);
    cmp_flag(zero_flag, e_z);
    cmp_flag(discard, e_skip);
    cmp_flag(file_we, 1'b0);
    // first edge after release is idle, instr_valid stays low over it
    @(negedge ref_clk);
    cmp_addr(pc, e_pc);
    cmp_flag(discard, e_skip);
  endtask
  // called at a falling edge, returns at the next falling edge
  task automatic step(input logic [13:0] w, input logic vld);
    instr = w;
    instr_valid = vld;
    pc_high_latch = 8'($urandom);
    v = m[w[6:0]];
    e_we = 0;
    @(posedge ref_clk);
    // an absent word changes nothing; a pending flush waits for the next one
    if (vld && e_skip) begin
      e_skip = 0;
      e_pc++;
    end else if (vld) begin
      r = v;
      case (w[13:8])
        `ABX_OPC_COMPLEMENT: r = ~v;
        `ABX_OPC_DECREMENT: r = v - 8'h01;
        `ABX_OPC_DEC_SKIP: r = v - 8'h01;
        `ABX_OPC_INC_SKIP: r = v + 8'h01;
        `ABX_OPC_OR_LITERAL: r = e_acc | w[7:0];
        default: ;
      endcase
      if (w[13:8] inside {`ABX_OPC_COMPLEMENT, `ABX_OPC_DECREMENT, `ABX_OPC_OR_LITERAL})
        e_z = (r == 8'h00);
      if (w[13:8] inside {`ABX_OPC_DEC_SKIP, `ABX_OPC_INC_SKIP})
        e_skip = (r == 8'h00);
      if (w[13:8] == `ABX_OPC_OR_LITERAL)
        e_acc = r;
      if (w[13:8] inside {`ABX_OPC_COMPLEMENT, `ABX_OPC_DECREMENT, `ABX_OPC_DEC_SKIP,
          `ABX_OPC_INC_SKIP}) begin
        if (w[`ABX_DEST_BIT]) begin
          e_we = 1;
          e_wd = r;
          m[w[6:0]] = r;
        end else begin
          e_acc = r;
        end
      end
      if (w[13:11] == `ABX_OPC_BRANCH) begin
        e_pc = {pc_high_latch[4:3], w[10:0]};
        e_skip = 1;
      end else begin
        e_pc++;
      end
    end
    @(negedge ref_clk);
    cmp_data(accum, e_acc);
    cmp_flag(zero_flag, e_z);
    cmp_addr(pc, e_pc);
    cmp_flag(discard, e_skip);
    cmp_flag(file_we, e_we);
    cmp_addr(13'(file_addr), 13'(w[6:0]));
    if (e_we) cmp_data(file_wdata, e_wd);
  endtask
  initial begin
    #200000;
    err_count++;
    close_out();
  end
  initial begin
    for (int i = 0; i < 128; i++) m[i] = 8'h00;
    void'($urandom(60393));
    do_reset();
    for (int n = 0; n < 1500; n++) begin
      // second reset mid-run, once the last file write has landed
      if (n == 750) begin
        instr_valid = 0;
        @(negedge ref_clk);
        do_reset();
      end
      k = $urandom % 7;
      w = {ops[k], 8'($urandom)};
      // few addresses so counts reach zero often
      if (k < 4) w[6:2] = 5'h00;
      if (k == 5) w[10:8] = 3'($urandom);
      // words go missing now and then, so a flush has to wait for one
      step(w, ($urandom % 8) != 0);
    end
    close_out();
  end
endmodule
`default_nettype wire
